// ---- hw/ssr_pkg.sv ----
// ssr_pkg: constants shared by the status byte and service request block.
// assumes: included before any design file that imports it.
`default_nettype none

package ssr_pkg;

  // ****************************************************************
  // widths and group numbering
  // ****************************************************************
  localparam int unsigned SSR_BYTE_W = 8;
  localparam int unsigned SSR_GRP_W = 16;
  localparam int unsigned SSR_STD_EV_W = 8;
  localparam int unsigned SSR_NUM_GRP = 5;
  localparam int unsigned SSR_RST_SYNC_W = 2;

  // group index into the per-group port vectors
  localparam int unsigned SSR_GRP_HW1 = 0;
  localparam int unsigned SSR_GRP_HW2 = 1;
  localparam int unsigned SSR_GRP_QUES = 2;
  localparam int unsigned SSR_GRP_OPER = 3;
  localparam int unsigned SSR_GRP_STD = 4;

  // ****************************************************************
  // status byte bit positions
  // ****************************************************************
  localparam int unsigned SSR_SB_HW1_BIT = 0;
  localparam int unsigned SSR_SB_HW2_BIT = 1;
  localparam int unsigned SSR_SB_UNUSED_BIT = 2;
  localparam int unsigned SSR_SB_QUES_BIT = 3;
  localparam int unsigned SSR_SB_MSG_AVAIL_BIT = 4;
  localparam int unsigned SSR_SB_STD_EV_BIT = 5;
  localparam int unsigned SSR_SB_REQ_SVC_BIT = 6;
  localparam int unsigned SSR_SB_OPER_BIT = 7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [SSR_BYTE_W-1:0] SSR_BYTE_RST = 8'h00;
  localparam logic [SSR_BYTE_W-1:0] SSR_SRE_RST = 8'h00;

endpackage : ssr_pkg

`default_nettype wire

// ---- hw/ssr_status_byte.sv ----
// ssr_status_byte: event/enable groups, the status byte, service request
// enable, request-service flag and the two read paths of the byte.
// assumes: one 100 MHz clock; all inputs but rst_n_i synchronous to it; command
// strobes (poll, query, clear, writes) are one-cycle pulses from the
// bus interface and command parser outside this block.
//
// Operation
// - keep an eight-bit status byte combining group summaries and bit 6
// - each group bit follows its group summary continuously
// - operation to bit 7, std event to bit 5, questionable to bit 3
// - hardware group two to bit 1, hardware group one to bit 0
// - bit 4 is high while the output queue holds unread data
// - a cascaded group summary may feed a group that feeds the byte
// - only bit 6 differs between serial poll and query readout
// - serial poll returns bit 6 as the request-service flag
// - serial poll clears request-service until a new reason arises
// - serial poll leaves bits 0 to 5 and 7 unchanged
// - master summary is OR of byte AND enable, bit 6 excluded
// - query reports bit 6 as master summary and modifies nothing
// - query answer is 0..255 weighted sum with 64 for master summary
// - status byte is read only; changes only with its summaries
// - clear-status empties every event register so summaries fall
// - clear-status leaves output queue and its available bit alone
// - an enabled condition asserts service request and sets the flag
// - group summary is OR of event AND enable bits; the code also ORs in grp_cascade_i, unmasked by any enable
// - event bits latch until queried or clear-status
`default_nettype none

module ssr_status_byte
  import ssr_pkg::*;
#(
  parameter int unsigned GRP_W = SSR_GRP_W,
  parameter int unsigned STD_W = SSR_STD_EV_W
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // per-group event sources, one-cycle set pulses per bit
  input wire logic [SSR_NUM_GRP-1:0][GRP_W-1:0] grp_event_set_i,
  // summaries of cascaded groups that feed each group
  input wire logic [SSR_NUM_GRP-1:0] grp_cascade_i,
  input wire logic [SSR_NUM_GRP-1:0] grp_enable_wr_i,
  input wire logic [GRP_W-1:0] grp_enable_data_i,
  input wire logic [SSR_NUM_GRP-1:0] grp_event_query_i,
  input wire logic clear_status_i,
  input wire logic outq_not_empty_i,
  input wire logic sre_wr_i,
  input wire logic [SSR_BYTE_W-1:0] sre_data_i,
  input wire logic serial_poll_i,
  input wire logic stb_query_i,
  output logic [GRP_W-1:0] grp_event_data_o,
  output logic grp_event_valid_o,
  output logic [SSR_BYTE_W-1:0] service_summary_byte_o,
  output logic [SSR_BYTE_W-1:0] sre_o,
  output logic request_service_flag_o,
  output logic srq_o,
  output logic [SSR_BYTE_W-1:0] poll_byte_o,
  output logic poll_valid_o,
  output logic [SSR_BYTE_W-1:0] stb_value_o,
  output logic stb_valid_o
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (STD_W < 1 || STD_W > GRP_W) begin : g_bad_width
    $error("ssr_status_byte: STD_W must lie in 1..GRP_W");
  end

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [SSR_RST_SYNC_W-1:0] rst_sync_q;
  logic rst_q;

  // async assert, clean release after two edges
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[SSR_RST_SYNC_W-2:0], 1'b1};
    end
  end
  assign rst_q = rst_sync_q[SSR_RST_SYNC_W-1];

  // ****************************************************************
  // helpers
  // ****************************************************************
  // valid bits of a group; the std event group is narrower
  function automatic logic [GRP_W-1:0] grp_mask(input int unsigned g);
    logic [GRP_W-1:0] m;
    m = '1;
    if (g == SSR_GRP_STD) begin
      m = m >> (GRP_W - STD_W);
    end
    return m;
  endfunction : grp_mask

  // summary message of one group
  function automatic logic grp_summary(input logic [GRP_W-1:0] ev,
                                       input logic [GRP_W-1:0] en);
    return |(ev & en);
  endfunction : grp_summary

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [SSR_NUM_GRP-1:0][GRP_W-1:0] ev;
    logic [SSR_NUM_GRP-1:0][GRP_W-1:0] en;
    logic [SSR_BYTE_W-1:0] sre;
    logic [SSR_BYTE_W-1:0] sb;
    logic [SSR_BYTE_W-1:0] mprev;
    logic req_svc;
    logic [SSR_BYTE_W-1:0] poll_byte;
    logic poll_valid;
    logic [SSR_BYTE_W-1:0] stb_value;
    logic stb_valid;
    logic [GRP_W-1:0] ev_data;
    logic ev_valid;
  } ssr_state_t;

  ssr_state_t s_q;
  ssr_state_t s_d;

  logic [SSR_NUM_GRP-1:0] summ;
  logic [SSR_BYTE_W-1:0] live;
  logic [SSR_BYTE_W-1:0] masked;
  logic [SSR_BYTE_W-1:0] rising;
  logic master_summary_flag;
  logic found;

  // ****************************************************************
  // next state
  // ****************************************************************
  // the readout valid flags are pulses; everything else holds
  always_comb begin
    s_d = s_q;
    s_d.poll_valid = 1'b0;
    s_d.stb_valid = 1'b0;
    s_d.ev_valid = 1'b0;
    found = 1'b0;

    // summaries come from registered events, so a query pulse and the
    // byte agree on one cycle's view
    for (int unsigned g = 0; g < SSR_NUM_GRP; g++) begin
      summ[g] = grp_summary(s_q.ev[g], s_q.en[g])
                | grp_cascade_i[g];
    end

    // assemble the byte; bit 6 is filled per read path
    live = SSR_BYTE_RST;
    live[SSR_SB_HW1_BIT] = summ[SSR_GRP_HW1];
    live[SSR_SB_HW2_BIT] = summ[SSR_GRP_HW2];
    live[SSR_SB_QUES_BIT] = summ[SSR_GRP_QUES];
    live[SSR_SB_STD_EV_BIT] = summ[SSR_GRP_STD];
    live[SSR_SB_OPER_BIT] = summ[SSR_GRP_OPER];
    live[SSR_SB_MSG_AVAIL_BIT] = outq_not_empty_i;
    live[SSR_SB_UNUSED_BIT] = 1'b0;

    // master summary, bit 6 kept out of the combination
    masked = live & s_q.sre;
    masked[SSR_SB_REQ_SVC_BIT] = 1'b0;
    master_summary_flag = |masked;

    // a new reason is a freshly risen enabled bit
    rising = masked & ~s_q.mprev;
    s_d.mprev = masked;

    // request-service: a rising reason beats a poll in the same cycle,
    // so the new reason is never lost; it also drops once no enabled
    // condition remains
    if (|rising) begin
      s_d.req_svc = 1'b1;
    end else if (serial_poll_i || !master_summary_flag) begin
      s_d.req_svc = 1'b0;
    end

    // byte seen by the outside world; it has no write path
    s_d.sb = live;
    s_d.sb[SSR_SB_REQ_SVC_BIT] = master_summary_flag;

    // serial poll: bit 6 is the flag as it stood before the poll
    if (serial_poll_i) begin
      s_d.poll_byte = live;
      s_d.poll_byte[SSR_SB_REQ_SVC_BIT] = s_q.req_svc;
      s_d.poll_valid = 1'b1;
    end

    // query: value bound for the output queue, no side effect
    if (stb_query_i) begin
      s_d.stb_value = live;
      s_d.stb_value[SSR_SB_REQ_SVC_BIT] = master_summary_flag;
      s_d.stb_valid = 1'b1;
    end

    // enable writes; unused bits of the narrow group are dropped
    for (int unsigned g = 0; g < SSR_NUM_GRP; g++) begin
      if (grp_enable_wr_i[g]) begin
        s_d.en[g] = grp_enable_data_i & grp_mask(g);
      end
    end
    if (sre_wr_i) begin
      s_d.sre = sre_data_i;
      s_d.sre[SSR_SB_REQ_SVC_BIT] = 1'b0;
    end

    // event query readout: lowest group index wins if several collide
    for (int unsigned g = 0; g < SSR_NUM_GRP; g++) begin
      if (grp_event_query_i[g] && !found) begin
        s_d.ev_data = s_q.ev[g];
        s_d.ev_valid = 1'b1;
        found = 1'b1;
      end
    end

    // events latch; a set arriving with a clear survives it
    for (int unsigned g = 0; g < SSR_NUM_GRP; g++) begin
      if (clear_status_i || grp_event_query_i[g]) begin
        s_d.ev[g] = '0;
      end
      s_d.ev[g] = (s_d.ev[g] | grp_event_set_i[g])
                  & grp_mask(g);
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_q) begin
    if (!rst_q) begin
      s_q <= '0;
      s_q.sre <= SSR_SRE_RST;
      s_q.sb <= SSR_BYTE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign grp_event_data_o = s_q.ev_data;
  assign grp_event_valid_o = s_q.ev_valid;
  assign service_summary_byte_o = s_q.sb;
  assign sre_o = s_q.sre;
  assign request_service_flag_o = s_q.req_svc;
  assign srq_o = s_q.req_svc;
  assign poll_byte_o = s_q.poll_byte;
  assign poll_valid_o = s_q.poll_valid;
  assign stb_value_o = s_q.stb_value;
  assign stb_valid_o = s_q.stb_valid;

  // ****************************************************************
  // checks
  // ****************************************************************
  // every bit of the byte except the one whose meaning depends on the path
  localparam logic [SSR_BYTE_W-1:0] NON_FLAG_MASK =
    ~(SSR_BYTE_W'(1) << SSR_SB_REQ_SVC_BIT);

  // group bits trail their summaries by one cycle
  AST_GROUP_BITS: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    ##1 (service_summary_byte_o[SSR_SB_OPER_BIT] == $past(summ[SSR_GRP_OPER]))
    && (service_summary_byte_o[SSR_SB_QUES_BIT] == $past(summ[SSR_GRP_QUES]))
    && (service_summary_byte_o[SSR_SB_STD_EV_BIT]
        == $past(summ[SSR_GRP_STD])))
    else $error("group bit does not follow its summary");

  AST_HW_BITS: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    ##1 (service_summary_byte_o[SSR_SB_HW1_BIT] == $past(summ[SSR_GRP_HW1]))
    && (service_summary_byte_o[SSR_SB_HW2_BIT] == $past(summ[SSR_GRP_HW2])))
    else $error("hardware group bit does not follow its summary");

  AST_MSG_AVAIL: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    ##1 service_summary_byte_o[SSR_SB_MSG_AVAIL_BIT]
        == $past(outq_not_empty_i))
    else $error("message available bit wrong");

  AST_UNUSED_ZERO: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    !service_summary_byte_o[SSR_SB_UNUSED_BIT]
    && !poll_byte_o[SSR_SB_UNUSED_BIT] && !stb_value_o[SSR_SB_UNUSED_BIT])
    else $error("unused bit reads one");

  AST_POLL_BIT6: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    serial_poll_i |=> poll_valid_o
    && (poll_byte_o[SSR_SB_REQ_SVC_BIT] == $past(srq_o)))
    else $error("poll bit 6 is not the request-service flag");

  AST_POLL_CLEARS: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    (serial_poll_i && !(|rising)) |=> !srq_o)
    else $error("poll did not clear request-service");

  // the poll answer and the byte are built from the same cycle's view
  AST_PATHS_AGREE: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    serial_poll_i |=>
    ((poll_byte_o ^ service_summary_byte_o) & NON_FLAG_MASK) == '0)
    else $error("read paths differ outside bit 6");

  AST_QUERY_VALUE: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    stb_query_i |=> stb_value_o == service_summary_byte_o)
    else $error("query answer differs from the status byte");

  AST_QUERY_KEEPS_FLAG: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    (stb_query_i && !serial_poll_i && master_summary_flag && !(|rising))
    |=> srq_o == $past(srq_o))
    else $error("query changed the request-service flag");

  AST_MASTER_SUMMARY: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    stb_query_i |=> stb_valid_o
    && stb_value_o[SSR_SB_REQ_SVC_BIT]
       == $past(|(live & s_q.sre & NON_FLAG_MASK)))
    else $error("query bit 6 is not the master summary");

  AST_RQS_RISE: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    (|rising) |=> srq_o && request_service_flag_o)
    else $error("new enabled reason did not request service");

  AST_NO_REASON: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    (!srq_o && !(|rising)) |=> !srq_o)
    else $error("service request without a new reason");

  AST_CLS_EMPTIES: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    (clear_status_i && grp_event_set_i == '0) |=> s_q.ev == '0)
    else $error("clear-status left an event bit set");

  AST_EV_HOLD: assert property (
    @(posedge clock_i) disable iff (!rst_q)
    (!clear_status_i && !grp_event_query_i[SSR_GRP_OPER]
     && s_q.ev[SSR_GRP_OPER][0]) |=> s_q.ev[SSR_GRP_OPER][0])
    else $error("latched event bit dropped");

endmodule : ssr_status_byte

`default_nettype wire

// ---- bench/ssr_ctrl_model.sv ----
// ssr_ctrl_model: bus controller that serial polls and queries the byte.
// assumes: shares the block clock; each request strobe lasts one cycle.
`default_nettype none

module ssr_ctrl_model
  import ssr_pkg::*;
(
  input wire logic clock_i,
  input wire logic [SSR_BYTE_W-1:0] poll_byte_i,
  input wire logic poll_valid_i,
  input wire logic [SSR_BYTE_W-1:0] stb_value_i,
  input wire logic stb_valid_i,
  output logic serial_poll_o,
  output logic stb_query_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // request strobes
  // ****************************************************************
  initial begin
    serial_poll_o = 1'b0;
    stb_query_o = 1'b0;
  end

  // strobe for one cycle, then wait a bounded time for the answer;
  // a missing answer comes back unknown so the caller's compare fails
  task automatic read_byte(input bit use_poll,
                           output logic [SSR_BYTE_W-1:0] b);
    int n;
    b = 'x;
    if (use_poll) begin
      serial_poll_o = 1'b1;
    end else begin
      stb_query_o = 1'b1;
    end
    @(posedge clock_i);
    #1;
    serial_poll_o = 1'b0;
    stb_query_o = 1'b0;
    for (n = 0; n < 4; n++) begin
      if (use_poll ? poll_valid_i : stb_valid_i) begin
        b = use_poll ? poll_byte_i : stb_value_i;
        break;
      end
      @(posedge clock_i);
      #1;
    end
    // one more edge so a following strobe never lands in this time step
    @(posedge clock_i);
    #1;
  endtask : read_byte

endmodule : ssr_ctrl_model

`default_nettype wire

// ---- bench/ssr_status_byte_tb_top.sv ----
// ssr_status_byte_tb_top: self-checking bench for the status byte block.
// assumes: ssr_pkg, the design and the controller model compiled first.
`default_nettype none

module ssr_status_byte_tb_top import ssr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

`define CHK(what, exp, got) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("MISMATCH %s exp %0h got %0h", what, exp, got); \
  end \
end

  // ****************************************************************
  // signals
  // ****************************************************************
  logic clock_i, rst_n_i, clear_status, outq_ne, sre_wr, serial_poll;
  logic stb_query, ev_valid, req_svc, srq, poll_valid, stb_valid;
  logic [SSR_NUM_GRP-1:0][SSR_GRP_W-1:0] ev_set;
  logic [SSR_NUM_GRP-1:0] cascade, en_wr, ev_query;
  logic [SSR_GRP_W-1:0] en_data, ev_data;
  logic [SSR_BYTE_W-1:0] sre_data, sb, sre, poll_byte, stb_value, rd;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int pos[SSR_NUM_GRP] = '{0, 1, 3, 7, 5};

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  ssr_status_byte u_ssr_status_byte (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .grp_event_set_i(ev_set),
    .grp_cascade_i(cascade), .grp_enable_wr_i(en_wr),
    .grp_enable_data_i(en_data), .grp_event_query_i(ev_query),
    .clear_status_i(clear_status), .outq_not_empty_i(outq_ne),
    .sre_wr_i(sre_wr), .sre_data_i(sre_data), .serial_poll_i(serial_poll),
    .stb_query_i(stb_query), .grp_event_data_o(ev_data),
    .grp_event_valid_o(ev_valid), .service_summary_byte_o(sb),
    .sre_o(sre), .request_service_flag_o(req_svc), .srq_o(srq),
    .poll_byte_o(poll_byte), .poll_valid_o(poll_valid),
    .stb_value_o(stb_value), .stb_valid_o(stb_valid));

  ssr_ctrl_model u_ssr_ctrl_model (
    .clock_i(clock_i), .poll_byte_i(poll_byte), .poll_valid_i(poll_valid),
    .stb_value_i(stb_value), .stb_valid_i(stb_valid),
    .serial_poll_o(serial_poll), .stb_query_o(stb_query));

  // ****************************************************************
  // access tasks; all drive one tick after the rising edge
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  task automatic pulse_event(input int g, input int b);
    ev_set[g][b] = 1'b1;
    tick(1);
    ev_set = '0;
  endtask : pulse_event

  task automatic wr_enable(input int g, input logic [SSR_GRP_W-1:0] d);
    en_wr[g] = 1'b1;
    en_data = d;
    tick(1);
    en_wr = '0;
  endtask : wr_enable

  task automatic pulse_clear();
    clear_status = 1'b1;
    tick(1);
    clear_status = 1'b0;
  endtask : pulse_clear

  task automatic results();
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // hang guard; the sequence needs well under 300 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      results();
    end
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    rst_n_i = 1'b0;
    ev_set = '0;
    cascade = '0;
    en_wr = '0;
    ev_query = '0;
    en_data = '0;
    clear_status = 1'b0;
    outq_ne = 1'b0;
    sre_wr = 1'b0;
    sre_data = '0;
    tick(12);
    rst_n_i = 1'b1;
    tick(3);
    `CHK("reset byte", SSR_BYTE_RST, sb)
    `CHK("reset sre", SSR_SRE_RST, sre)
    `CHK("reset srq", 1'b0, srq)
    // each group summary lands on its own position; bit 2 never set
    for (int g = 0; g < SSR_NUM_GRP; g++) begin
      wr_enable(g, 16'hffff);
      pulse_event(g, 0);
      tick(2);
      `CHK("group bit", 8'(1 << pos[g]), sb)
      ev_query[g] = 1'b1;
      tick(1);
      ev_query = '0;
      `CHK("event valid", 1'b1, ev_valid)
      `CHK("event data", 16'h0001, ev_data)
      tick(2);
      `CHK("group falls", 8'h00, sb)
    end
    // a masked event stays latched and shows once enabled
    wr_enable(SSR_GRP_HW1, 16'h0001);
    pulse_event(SSR_GRP_HW1, 1);
    tick(2);
    `CHK("masked", 8'h00, sb)
    wr_enable(SSR_GRP_HW1, 16'h0002);
    tick(2);
    `CHK("latched", 8'h01, sb)
    cascade[SSR_GRP_QUES] = 1'b1;
    outq_ne = 1'b1;
    tick(2);
    `CHK("cascade avail", 8'h19, sb)
    cascade = '0;
    pulse_clear();
    tick(2);
    `CHK("clear keeps avail", 8'h10, sb)
    outq_ne = 1'b0;
    tick(2);
    `CHK("avail low", 8'h00, sb)
    sre_wr = 1'b1;
    sre_data = 8'hff;
    tick(1);
    sre_wr = 1'b0;
    `CHK("sre", 8'hbf, sre)
    tick(2);
    `CHK("byte untouched", 8'h00, sb)
    `CHK("no request", 1'b0, srq)
    // an enabled condition raises the request
    outq_ne = 1'b1;
    tick(2);
    `CHK("srq", 1'b1, srq)
    `CHK("req svc flag", 1'b1, req_svc)
    `CHK("live summary", 8'h50, sb)
    u_ssr_ctrl_model.read_byte(1'b0, rd);
    `CHK("query", 8'h50, rd)
    `CHK("query keeps srq", 1'b1, srq)
    u_ssr_ctrl_model.read_byte(1'b1, rd);
    `CHK("poll", 8'h50, rd)
    `CHK("poll clears", 1'b0, srq)
    `CHK("poll keeps byte", 8'h50, sb)
    u_ssr_ctrl_model.read_byte(1'b1, rd);
    `CHK("repoll", 8'h10, rd)
    u_ssr_ctrl_model.read_byte(1'b0, rd);
    `CHK("query after poll", 8'h50, rd)
    tick(2);
    `CHK("no new reason", 1'b0, srq)
    // a newly risen enabled bit requests service again
    wr_enable(SSR_GRP_OPER, 16'h0004);
    pulse_event(SSR_GRP_OPER, 2);
    tick(2);
    `CHK("oper", 8'hd0, sb)
    `CHK("new srq", 1'b1, srq)
    u_ssr_ctrl_model.read_byte(1'b1, rd);
    `CHK("poll oper", 8'hd0, rd)
    pulse_clear();
    outq_ne = 1'b0;
    tick(2);
    u_ssr_ctrl_model.read_byte(1'b0, rd);
    `CHK("final query", 8'h00, rd)
    results();
  end

endmodule : ssr_status_byte_tb_top

`default_nettype wire
